// ==== include/pmc_if.sv ====
/*
  Carrier between the register front end and the per-function wake bank.
  Assumes both ends run on the same clock and clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
interface pmc_if #(
  parameter int unsigned NUM_FUNC = pmc_pkg::NUM_FUNC
);
  logic [NUM_FUNC-1:0] wr_wake;     // Write of the wake bit, per function
  logic                wr_bit;      // Value written to the wake bit
  logic [NUM_FUNC-1:0] enable;      // Wake_assert_enable of each function
  logic                global_rst;  // Global reset request
  logic                bus_rst;     // Bus reset request
  logic [NUM_FUNC-1:0] wake_d3cold; // Current wake bit of each function

  modport ctrl (
    output wr_wake,
    output wr_bit,
    output enable,
    output global_rst,
    output bus_rst,
    input  wake_d3cold
  );
  modport bank (
    input  wr_wake,
    input  wr_bit,
    input  enable,
    input  global_rst,
    input  bus_rst,
    output wake_d3cold
  );
endinterface
`default_nettype wire

// ==== include/pmc_pkg.sv ====
/*
  Constants for the power management capability registers: offsets,
  field positions, fixed values and reset values.
  Assumes byte-wide configuration access with one byte per address.
*/
// What this block does
// - Next pointer byte always reads zero.
// - Capabilities word at A2h, resets FE12h.
// - Each function keeps its own capabilities word.
// - Wake-from-D3cold bit resets one, software writable.
// - Zero PME-source bit means no PME there.
// - Bits 14 to 11 read-only, read one.
// - Bits 10 and 9 read-only, read one.
// - Bits 8 to 6 reserved, read zero.
// - Bit 5 read-only, reads zero.
// - Aux bit reads zero while bit 15 zero.
// - Bit 3 read-only, reads zero.
// - Bits 2 to 0 read version 010b.
// - Bus reset sets bit 15 only without PME.
// - PME-enabled taken from function's Wake_assert_enable bit.
// - Capability ID byte reads fixed code 01h.
`default_nettype none
package pmc_pkg;
  // Bus widths and function count
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned NUM_FUNC = 2;
  localparam int unsigned FUNC_W   = 1;
  // Byte offsets
  localparam logic [7:0] CAP_ID_OFS   = 8'hA0;
  localparam logic [7:0] NEXT_PTR_OFS = 8'hA1;
  localparam logic [7:0] CAPS_LO_OFS  = 8'hA2;
  localparam logic [7:0] CAPS_HI_OFS  = 8'hA3;
  // Fixed byte values
  localparam logic [7:0] CAP_ID_VAL   = 8'h01;
  localparam logic [7:0] NEXT_PTR_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  // Capabilities word reset value
  localparam logic [15:0] CAPS_RESET  = 16'hFE12;
  // Field positions in the capabilities word
  localparam int unsigned WAKE_D3COLD_BIT = 15;
  localparam int unsigned PME_SRC_HI      = 14;
  localparam int unsigned PME_SRC_LO      = 11;
  localparam int unsigned STATE_TWO_BIT   = 10;
  localparam int unsigned STATE_ONE_BIT   = 9;
  localparam int unsigned RSVD_HI         = 8;
  localparam int unsigned RSVD_LO         = 6;
  localparam int unsigned DSI_BIT         = 5;
  localparam int unsigned AUX_BIT         = 4;
  localparam int unsigned CLK_BIT         = 3;
  localparam int unsigned VER_HI          = 2;
  localparam int unsigned VER_LO          = 0;
  // Bit 15 within the high byte
  localparam int unsigned WAKE_BYTE_BIT   = 7;
  // Field values
  localparam logic [3:0] PME_SRC_VAL   = 4'hF;
  localparam logic [2:0] RSVD_VAL      = 3'h0;
  localparam logic [2:0] VERSION_VAL   = 3'h2;
  localparam logic       WAKE_RESET    = 1'b1;
  localparam logic       AUX_DEFAULT   = 1'b1;
endpackage
`default_nettype wire

// ==== logic/pmc_capability_registers.sv ====
/*
  Power management capability registers of the bridge functions:
  capability ID, next pointer and the 16-bit capabilities word.
  Assumes a byte-wide configuration port whose strobes are one cycle
  long, and a Wake_assert_enable bit kept elsewhere for each function.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pmc_capability_registers #(
  parameter int unsigned NUM_FUNC    = pmc_pkg::NUM_FUNC,
  parameter int unsigned FUNC_W      = pmc_pkg::FUNC_W,
  parameter logic        AUX_NEEDED  = pmc_pkg::AUX_DEFAULT
) (
  // Clock, reset and clock enable
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic                        clock_en,
  // Reset requests from the rest of the bridge
  input  wire logic                        global_reset_in,
  input  wire logic                        bus_reset_in,
  // Wake_assert_enable bit of each function
  input  wire logic [NUM_FUNC-1:0]         wake_assert_enable,
  // Configuration port
  input  wire logic [FUNC_W-1:0]           func_sel,
  input  wire logic [pmc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [pmc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [pmc_pkg::DATA_W-1:0]  reg_rdata,
  // State seen by the wake logic of each function
  output logic      [NUM_FUNC-1:0]         wake_d3cold_out,
  output logic      [NUM_FUNC-1:0]         aux_supply_needed
);

  // Carrier to the wake bank
  pmc_if #(.NUM_FUNC(NUM_FUNC)) wake_bus ();

  // Read data register and its next value
  logic [pmc_pkg::DATA_W-1:0] rdata_r;
  logic [pmc_pkg::DATA_W-1:0] rdata_nxt;

  // Registered copies of the wake and aux bits
  logic [NUM_FUNC-1:0]        wake_out_r;
  logic [NUM_FUNC-1:0]        wake_out_nxt;
  logic [NUM_FUNC-1:0]        aux_out_r;
  logic [NUM_FUNC-1:0]        aux_out_nxt;

  // Decoded function select and its validity
  logic                       func_valid;
  logic [NUM_FUNC-1:0]        func_hit;

  // Capabilities word of the selected function
  logic [15:0]                sel_word;

  // Builds the capabilities word from the one live bit
  function automatic logic [15:0] caps_word(
    input logic wake,
    input logic aux
  );
    logic [15:0] w;
    w = 16'h0000;
    // Writable wake-from-D3cold bit
    w[pmc_pkg::WAKE_D3COLD_BIT] = wake;
    // PME possible from D3hot, D2, D1 and D0
    w[pmc_pkg::PME_SRC_HI:pmc_pkg::PME_SRC_LO] = pmc_pkg::PME_SRC_VAL;
    // Both intermediate power states supported
    w[pmc_pkg::STATE_TWO_BIT] = 1'b1;
    w[pmc_pkg::STATE_ONE_BIT] = 1'b1;
    // Reserved field
    w[pmc_pkg::RSVD_HI:pmc_pkg::RSVD_LO] = pmc_pkg::RSVD_VAL;
    // No device-specific initialization
    w[pmc_pkg::DSI_BIT] = 1'b0;
    // Aux indication is meaningless without D3cold wake, so it is masked
    w[pmc_pkg::AUX_BIT] = wake & aux;
    // PME generation does not need the bus clock
    w[pmc_pkg::CLK_BIT] = 1'b0;
    // Version of the register set
    w[pmc_pkg::VER_HI:pmc_pkg::VER_LO] = pmc_pkg::VERSION_VAL;
    return w;
  endfunction

  // Picks the byte that a read at addr returns
  function automatic logic [7:0] read_byte(
    input logic [7:0]  addr,
    input logic [15:0] word,
    input logic        valid
  );
    logic [7:0] b;
    b = pmc_pkg::UNMAPPED_VAL;
    if (valid) begin
      unique case (addr)
        // Fixed power management ID
        pmc_pkg::CAP_ID_OFS:   b = pmc_pkg::CAP_ID_VAL;
        // End of the capability list
        pmc_pkg::NEXT_PTR_OFS: b = pmc_pkg::NEXT_PTR_VAL;
        // Low byte of the capabilities word
        pmc_pkg::CAPS_LO_OFS:  b = word[7:0];
        // High byte of the capabilities word
        pmc_pkg::CAPS_HI_OFS:  b = word[15:8];
        // Anything else in the space reads zero
        default:               b = pmc_pkg::UNMAPPED_VAL;
      endcase
    end
    return b;
  endfunction

  // Function decode; a select beyond the last function is ignored
  always_comb begin
    func_hit   = '0;
    func_valid = 1'b0;
    for (int f = 0; f < NUM_FUNC; f++) begin
      if (func_sel == FUNC_W'(f)) begin
        func_hit[f] = 1'b1;
        func_valid  = 1'b1;
      end
    end
  end

  // Word of the selected function, taken from its own copy
  always_comb begin
    sel_word = caps_word(pmc_pkg::WAKE_RESET, AUX_NEEDED);
    for (int f = 0; f < NUM_FUNC; f++) begin
      if (func_hit[f]) begin
        sel_word = caps_word(wake_bus.wake_d3cold[f], AUX_NEEDED);
      end
    end
  end

  // Requests to the wake bank
  always_comb begin
    // Only bit 15 of the high byte is stored; the other written
    // bits fall on read-only fields and are dropped
    wake_bus.wr_bit     = reg_wdata[pmc_pkg::WAKE_BYTE_BIT];
    wake_bus.wr_wake    = '0;
    if (reg_wr && (reg_addr == pmc_pkg::CAPS_HI_OFS)) begin
      // Write reaches only the selected function's copy
      wake_bus.wr_wake  = func_hit;
    end
    // Context reset conditions
    wake_bus.global_rst = global_reset_in;
    wake_bus.bus_rst    = bus_reset_in;
    // Wake_assert_enable steers whether the bus reset may act
    wake_bus.enable     = wake_assert_enable;
  end

  // Per-function context bits
  pmc_wake_bank #(
    .NUM_FUNC (NUM_FUNC)
  ) u_wake_bank (
    .clock    (clock),
    .reset    (reset),
    .clock_en (clock_en),
    .bus      (wake_bus.bank)
  );

  // Next read data: valid only in the cycle after a read strobe,
  // zero otherwise so that a stale byte lingers on the port only while the clock enable is low
  always_comb begin
    rdata_nxt = pmc_pkg::UNMAPPED_VAL;
    if (reg_rd) begin
      rdata_nxt = read_byte(reg_addr, sel_word, func_valid);
    end
  end

  // Next values of the status outputs
  always_comb begin
    wake_out_nxt = wake_bus.wake_d3cold;
    aux_out_nxt  = '0;
    for (int f = 0; f < NUM_FUNC; f++) begin
      // Aux need is only reported while D3cold wake is allowed
      aux_out_nxt[f] = wake_bus.wake_d3cold[f] & AUX_NEEDED;
    end
  end

  // Register stage for read data and status outputs.
  // The status copies trail the bank by one cycle; this keeps every
  // output straight from a flip-flop at the cost of that latency.
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_r    <= pmc_pkg::UNMAPPED_VAL;
      wake_out_r <= {NUM_FUNC{pmc_pkg::WAKE_RESET}};
      // Follows the wake default, so a build without aux need resets to zero
      aux_out_r  <= {NUM_FUNC{pmc_pkg::WAKE_RESET & AUX_NEEDED}};
    end else if (clock_en) begin
      rdata_r    <= rdata_nxt;
      wake_out_r <= wake_out_nxt;
      aux_out_r  <= aux_out_nxt;
    end
  end

  // Output drive
  assign reg_rdata         = rdata_r;
  assign wake_d3cold_out   = wake_out_r;
  assign aux_supply_needed = aux_out_r;

endmodule // pmc_capability_registers
`default_nettype wire

// ==== logic/pmc_wake_bank.sv ====
/*
  Per-function wake-from-D3cold context bits.
  Assumes requests arrive from the front end through pmc_if.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_bank #(
  parameter int unsigned NUM_FUNC = pmc_pkg::NUM_FUNC
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clock_en,
  pmc_if.bank       bus
);
  // One context bit for each function
  logic [NUM_FUNC-1:0] wake_r;
  logic [NUM_FUNC-1:0] wake_nxt;

  // Next value: resets return the bit to its default, writes load it
  always_comb begin
    wake_nxt = wake_r;
    for (int f = 0; f < NUM_FUNC; f++) begin
      if (bus.global_rst) begin
        // Global reset always restores the default
        wake_nxt[f] = pmc_pkg::WAKE_RESET;
      end else if (bus.bus_rst && !bus.enable[f]) begin
        // Bus reset only touches a function whose PME is disabled
        wake_nxt[f] = pmc_pkg::WAKE_RESET;
      end else if (bus.wr_wake[f]) begin
        // Software may clear it when no aux supply exists
        wake_nxt[f] = bus.wr_bit;
      end
    end
  end

  // Register stage, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_r <= {NUM_FUNC{pmc_pkg::WAKE_RESET}};
    end else if (clock_en) begin
      wake_r <= wake_nxt;
    end
  end

  assign bus.wake_d3cold = wake_r;
endmodule // pmc_wake_bank
`default_nettype wire

// ==== sim/pmc_props.sv ====
/*
  Checker for the capability registers: read bytes, wake bit, aux flag.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_props #(
  parameter int unsigned NUM_FUNC   = pmc_pkg::NUM_FUNC,
  parameter int unsigned FUNC_W     = pmc_pkg::FUNC_W,
  parameter logic        AUX_NEEDED = pmc_pkg::AUX_DEFAULT
) (
  input wire logic                clock,
  input wire logic                reset,
  input wire logic                clock_en,
  input wire logic                global_reset_in,
  input wire logic                bus_reset_in,
  input wire logic [NUM_FUNC-1:0] wake_assert_enable,
  input wire logic [FUNC_W-1:0]   func_sel,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic [NUM_FUNC-1:0] wake_d3cold_out,
  input wire logic [NUM_FUNC-1:0] aux_supply_needed
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Accepted strobes; a write carries no reset of the same cycle
  logic rd_go;
  logic wr_go;
  assign rd_go = clock_en & reg_rd;
  assign wr_go = clock_en & reg_wr & ~global_reset_in & ~bus_reset_in;

  a_rdata_idle: assert property (clock_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle after a cycle with no read");
  a_cap_id_byte: assert property (rd_go && reg_addr == 8'hA0 |=> reg_rdata == 8'h01)
    else $error("capability id byte wrong");
  a_next_ptr_zero: assert property (rd_go && reg_addr == 8'hA1 |=> reg_rdata == 8'h00)
    else $error("next pointer byte not zero");
  // Low byte: reserved, init, clock and version fields are fixed
  a_caps_low_fixed: assert property (rd_go && reg_addr == 8'hA2 |=>
    reg_rdata[7:5] == 3'h0 && reg_rdata[3:0] == 4'h2) else $error("low capability byte wrong");
  a_caps_high_fixed: assert property (rd_go && reg_addr == 8'hA3 |=>
    reg_rdata[6:0] == 7'h7E) else $error("high capability byte wrong");
  a_aux_follows_wake: assert property (aux_supply_needed ==
    (wake_d3cold_out & {NUM_FUNC{AUX_NEEDED}})) else $error("aux flag not tied to wake bit");
  // The status copies only follow the bank on an enabled edge, so the
  // second cycle of each of these needs the clock enable high as well
  a_global_sets: assert property (clock_en && global_reset_in ##1 clock_en |=>
    wake_d3cold_out == {NUM_FUNC{1'b1}}) else $error("global reset left wake bit clear");
  a_bus_sets_idle: assert property (clock_en && bus_reset_in ##1 clock_en |=>
    (wake_d3cold_out | $past(wake_assert_enable, 2)) == {NUM_FUNC{1'b1}})
    else $error("bus reset missed a function without wake enable");
  a_bus_keeps_armed: assert property (clock_en && bus_reset_in && !global_reset_in
    && !reg_wr ##1 clock_en |=> ((wake_d3cold_out ^ $past(wake_d3cold_out)) &
    $past(wake_assert_enable, 2)) == '0) else $error("bus reset changed an armed function");
  a_write_wake: assert property (wr_go && reg_addr == 8'hA3 ##1 clock_en |=>
    wake_d3cold_out[$past(func_sel, 2)] == $past(reg_wdata[7], 2))
    else $error("wake bit did not take written value");
  a_ro_write_void: assert property (wr_go && reg_addr != 8'hA3 ##1 clock_en |=>
    $stable(wake_d3cold_out)) else $error("write elsewhere changed wake bit");

  // Main scenarios seen at least once
  c_wake_cleared: cover property (wr_go && reg_addr == 8'hA3 && !reg_wdata[7]);
  c_bus_mixed: cover property (clock_en && bus_reset_in && ^wake_assert_enable);
  c_global: cover property (clock_en && global_reset_in);
  c_frozen_read: cover property (!clock_en && reg_rd);
endmodule // pmc_props
bind pmc_capability_registers pmc_props #(.NUM_FUNC(NUM_FUNC), .FUNC_W(FUNC_W),
  .AUX_NEEDED(AUX_NEEDED)) u_props (.clock, .reset, .clock_en, .global_reset_in,
  .bus_reset_in, .wake_assert_enable, .func_sel, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .wake_d3cold_out, .aux_supply_needed);
`default_nettype wire

// ==== sim/test_pm_capability_registers.sv ====
/*
  Self-checking bench for the capability registers, with a model of both functions.
  Assumes the default parameters of the top module; the clock enable drops at random.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pm_capability_registers;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       clock_en = 1'b1;
  logic       global_reset_in = 1'b0;
  logic       bus_reset_in = 1'b0;
  logic [1:0] wake_assert_enable = 2'b00;
  logic [0:0] func_sel = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] wake_d3cold_out;
  logic [1:0] aux_supply_needed;
  logic [1:0] w;              // Model wake bit per function
  logic [1:0] w_lag;          // Model of the one-cycle lagged outputs
  logic [7:0] exp_rd = 8'h00; // Expected read byte for the next edge
  logic       chk_on = 1'b0;
  logic [31:0] r;
  integer     seed = 33;
  int         error_cnt = 0;
  int         samples_checked = 0;

  always #5 clock = ~clock;

  pmc_capability_registers DUT (.clock(clock), .reset(reset), .clock_en(clock_en),
    .global_reset_in(global_reset_in), .bus_reset_in(bus_reset_in),
    .wake_assert_enable(wake_assert_enable), .func_sel(func_sel), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_d3cold_out(wake_d3cold_out), .aux_supply_needed(aux_supply_needed));

  task automatic mism(input string m);
    error_cnt++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  // Byte seen by software, worked out from the fixed field values
  function automatic logic [7:0] cfg_byte(input logic [7:0] a, input logic wk);
    case (a)
      8'hA0: return 8'h01;
      8'hA1: return 8'h00;
      8'hA2: return {3'h0, wk, 4'h2};
      8'hA3: return {wk, 7'h7E};
      default: return 8'h00;
    endcase
  endfunction

  // Model steps on the same edge the design samples; compare first, then update
  always @(posedge clock) begin
    if (chk_on) begin
      samples_checked++;
      if (reg_rdata !== exp_rd) mism("read byte");
      if (wake_d3cold_out !== w_lag) mism("wake bit");
      if (aux_supply_needed !== w_lag) mism("aux flag");
    end
    // Reset acts whatever the enable; a low enable freezes the model like the design
    if (reset) begin
      exp_rd = 8'h00;
      w_lag = 2'b11;
      w = 2'b11;
    end else if (clock_en) begin
      exp_rd = reg_rd ? cfg_byte(reg_addr, w[func_sel]) : 8'h00;
      w_lag = w;
      if (global_reset_in) begin
        w = 2'b11;
      end else begin
        if (bus_reset_in) w = w | ~wake_assert_enable;
        // A bus reset on an unarmed function beats a write to it
        if (reg_wr && reg_addr == 8'hA3 && !(bus_reset_in && !wake_assert_enable[func_sel]))
          w[func_sel] = reg_wdata[7];
      end
    end
  end

  task automatic drive(input logic rd, input logic wr, input logic f, input logic [7:0] a,
                       input logic [7:0] d);
    @(posedge clock);
    reg_rd <= rd;
    reg_wr <= wr;
    func_sel <= f;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task automatic tally_and_finish;
    $display("Errors %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Hang guard, well beyond the few thousand cycles of the run
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    chk_on <= 1'b1;
    // Back-to-back clear, read-back and function isolation
    drive(1'b0, 1'b1, 1'b1, 8'hA3, 8'h00);
    drive(1'b1, 1'b0, 1'b1, 8'hA3, 8'h00);
    drive(1'b1, 1'b0, 1'b0, 8'hA3, 8'h00);
    drive(1'b1, 1'b0, 1'b1, 8'hA2, 8'h00);
    drive(1'b0, 1'b1, 1'b0, 8'hA2, 8'hFF);
    drive(1'b0, 1'b1, 1'b0, 8'hA1, 8'hFF);
    drive(1'b1, 1'b0, 1'b0, 8'hA1, 8'h00);
    drive(1'b1, 1'b0, 1'b0, 8'h55, 8'h00);
    // Random traffic with resets of both kinds and a mid-run reset
    for (int i = 0; i < 3000; i++) begin
      r = $random(seed);
      @(posedge clock);
      reg_rd <= r[0] & ~r[1];
      reg_wr <= r[1] & ~r[0];
      func_sel <= r[2];
      reg_addr <= (r[6:5] == 2'b11) ? r[15:8] : 8'hA0 + {6'h00, r[4:3]};
      reg_wdata <= r[23:16];
      wake_assert_enable <= r[25:24];
      bus_reset_in <= (r[29:26] == 4'h0);
      global_reset_in <= (r[31:26] == 6'h3F);
      reset <= (i == 1500);
      // Clock enable low about one edge in four
      clock_en <= ~(r[7] & r[3]);
    end
    drive(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    clock_en <= 1'b1;
    repeat (4) @(posedge clock);
    tally_and_finish();
  end
endmodule // test_pm_capability_registers
`default_nettype wire
